// ---- pkg/kds_pkg.sv ----
/*
 Constants shared by the keyboard/display scanner: command codes, reset values,
 status word layout, pin bundle layout and timebase-derived counts.
 Assumes the internal timebase is programmed near 100 kHz by the host.
*/
package kds_pkg;

  // Command opcodes in data bits 7:5
  localparam logic [2:0] CMD_MODE = 3'h0;
  localparam logic [2:0] CMD_CLOCK = 3'h1;
  localparam logic [2:0] CMD_READ_FIFO = 3'h2;
  localparam logic [2:0] CMD_READ_DISP = 3'h3;
  localparam logic [2:0] CMD_WRITE_DISP = 3'h4;
  localparam logic [2:0] CMD_INHIBIT = 3'h5;

  // Values after reset, and the smallest prescale value used
  localparam logic [1:0] DISP_MODE_RESET = 2'h1;
  localparam logic [2:0] KBD_MODE_RESET = 3'h0;
  localparam logic [4:0] PRESCALE_RESET = 5'h1f;
  localparam logic [4:0] PRESCALE_MIN = 5'h02;

  // Status word bit positions
  localparam int ST_FULL = 3;
  localparam int ST_UNDER = 4;
  localparam int ST_OVER = 5;

  // Synchronised pin bundle: cs_n, a0, rd_n, wr_n, shift, cntl, return[7:0], data[7:0]
  localparam int PIN_W = 22;
  localparam int PIN_CS = 21;
  localparam int PIN_A0 = 20;
  localparam int PIN_RD = 19;
  localparam int PIN_WR = 18;
  localparam int PIN_SHIFT = 17;
  localparam int PIN_CNTL = 16;
  localparam int PIN_RL = 8;
  localparam logic [PIN_W-1:0] PIN_RESET = 22'h2fff00;

  // Timebase and scan timing, in the units printed
  localparam int TIMEBASE_HZ = 100_000;
  localparam int DIGIT_ON_US = 480;
  localparam int BLANK_US = 160;
  localparam int DEBOUNCE_US = 10_300;
  localparam int DIGIT_TICKS = (DIGIT_ON_US + BLANK_US) * TIMEBASE_HZ / 1_000_000;
  localparam int BLANK_TICKS = BLANK_US * TIMEBASE_HZ / 1_000_000;
  localparam int DEBOUNCE_TICKS = DEBOUNCE_US * TIMEBASE_HZ / 1_000_000;

  // Key capture states, Gray along idle-debounce-confirm-held
  typedef enum logic [1:0] {
    KDS_IDLE = 2'b00,
    KDS_DEBOUNCE = 2'b01,
    KDS_CONFIRM = 2'b11,
    KDS_HELD = 2'b10
  } kds_key_state_t;

endpackage : kds_pkg

// ---- src/kds_ram.sv ----
/*
 Small memory with one write port and two read ports whose data are registered.
 Assumes a single clock; contents are undefined until written.
*/
`timescale 1ns/100ps
module kds_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr_a,
  output logic [WIDTH-1:0] o_rdata_a,
  input wire logic [AW-1:0] i_raddr_b,
  output logic [WIDTH-1:0] o_rdata_b
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata_a <= '0;
      o_rdata_b <= '0;
    end else begin
      o_rdata_a <= mem[i_raddr_a];
      o_rdata_b <= mem[i_raddr_b];
    end
  end
endmodule : kds_ram

// ---- src/kds_top.sv ----
/*
 Keyboard/display scanner: host bus decode, prescaler, scan counter, key debounce,
 sensor matrix, strobed input, FIFO/sensor RAM, display RAM refresh.
 Assumes asynchronous host pins (synchronised here) and a 25 MHz I_CLK.
*/
// Behaviour
// - Bus driven only during selected reads
// - A0 high command/status, low data
// - Commands latched on write rising edge
// - Clock divided by prescale field, 2 to 31
// - Decoded one-of-four active low, encoded binary
// - Decoded keyboard shows only four digits
// - Debounce then store key, shift, control
// - Sensor rows copied each scan
// - Strobe rising edge loads return lines
// - Eight-entry FIFO with count, full, empty
// - Underrun and overrun flagged in status
// - Status read when A0 high
// - Interrupt high while FIFO not empty
// - Interrupt on sensor change
// - Display address with auto-increment
// - Mode command display field decode
// - Mode command keyboard field decode
// - FIFO reads ignore increment and row
// - Sensor row select with auto-increment
// - Nibbles B low, A high of byte
// - Blank during digit switch and command
// - Reset to 16 left, encoded lockout, 31
// - Interrupt drops during each FIFO read
`timescale 1ns/100ps
module kds_top (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_CS_N,
  input wire logic I_A0,
  input wire logic I_RD_N,
  input wire logic I_WR_N,
  input wire logic [7:0] I_DB,
  output logic [7:0] O_DB,
  output logic O_DB_OE,
  output logic O_IRQ,
  output logic [3:0] O_SCAN_LINES,
  input wire logic [7:0] I_RETURN_LINES,
  input wire logic I_SHIFT,
  input wire logic I_CONTROL_STROBE_INPUT,
  output logic [3:0] O_OUT_A,
  output logic [3:0] O_OUT_B,
  output logic O_BLANK_DISPLAY_OUT_N
);
  import kds_pkg::*;

  function automatic logic [2:0] low_col(input logic [7:0] rl);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (!rl[i]) idx = i[2:0];
    end
    return idx;
  endfunction : low_col

  logic [PIN_W-1:0] s1, s2, s3, pin_q;
  logic cs_act, rd_act, wr_act, rd_act_d, wr_act_d, rd_a0, wr_a0;
  logic rd_fall, rd_rise, wr_rise, cntl_d;
  logic [7:0] wr_data, rl;
  logic [1:0] disp_mode_field;
  logic [2:0] keyboard_mode_field;
  logic [4:0] prescale_field, pre_cnt;
  logic tick;
  logic [5:0] phase;
  logic [3:0] scan_row, digits;
  logic row_end, row_start, blank_phase, sensor_mode, strobe_mode, kbd_mode, decoded;
  kds_key_state_t key_state;
  logic [2:0] cand_row, cand_col;
  logic [10:0] deb_cnt;
  logic kbd_push, strobe_push, push, pop_req, sensor_we, sensor_irq, rd_hold;
  logic [7:0] key_code, fifo_q_a, fifo_q_b, disp_q_a, disp_q_b;
  logic [2:0] wr_ptr, rd_ptr, sens_ptr;
  logic [3:0] count, disp_addr;
  logic over_err, under_err, src_disp, auto_increment_flag, disp_auto_inc;
  logic iw_a, iw_b, bl_a, bl_b, disp_we;

  // Three-stage input synchroniser, change accepted when stages two and three agree
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      s1 <= PIN_RESET;
      s2 <= PIN_RESET;
      s3 <= PIN_RESET;
    end else begin
      s1 <= {I_CS_N, I_A0, I_RD_N, I_WR_N, I_SHIFT, I_CONTROL_STROBE_INPUT, I_RETURN_LINES, I_DB};
      s2 <= s1;
      s3 <= s2;
    end
  end

  for (genvar g = 0; g < PIN_W; g++) begin : g_filt
    always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
        pin_q[g] <= PIN_RESET[g];
      end else if (s2[g] == s3[g]) begin
        pin_q[g] <= s3[g];
      end
    end
  end

  assign cs_act = !pin_q[PIN_CS];
  assign rd_act = cs_act && !pin_q[PIN_RD];
  assign wr_act = cs_act && !pin_q[PIN_WR];
  assign rl = pin_q[PIN_RL +: 8];
  assign rd_fall = rd_act && !rd_act_d;
  assign rd_rise = !rd_act && rd_act_d;
  assign wr_rise = !wr_act && wr_act_d;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rd_act_d <= 1'b0;
      wr_act_d <= 1'b0;
      rd_a0 <= 1'b0;
      wr_a0 <= 1'b0;
      wr_data <= 8'h00;
      cntl_d <= 1'b1;
    end else begin
      rd_act_d <= rd_act;
      wr_act_d <= wr_act;
      cntl_d <= pin_q[PIN_CNTL];
      if (rd_fall) rd_a0 <= pin_q[PIN_A0];
      if (wr_act) begin
        wr_a0 <= pin_q[PIN_A0];
        wr_data <= pin_q[7:0];
      end
    end
  end

  // Command decode on the trailing edge of the write strobe
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      disp_mode_field <= DISP_MODE_RESET;
      keyboard_mode_field <= KBD_MODE_RESET;
      prescale_field <= PRESCALE_RESET;
      iw_a <= 1'b0;
      iw_b <= 1'b0;
      bl_a <= 1'b0;
      bl_b <= 1'b0;
    end else if (wr_rise && wr_a0) begin
      unique case (wr_data[7:5])
        CMD_MODE: begin
          disp_mode_field <= wr_data[4:3];
          keyboard_mode_field <= wr_data[2:0];
        end
        CMD_CLOCK: prescale_field <= wr_data[4:0];
        CMD_INHIBIT: begin
          iw_a <= wr_data[3];
          iw_b <= wr_data[2];
          bl_a <= wr_data[1];
          bl_b <= wr_data[0];
        end
        default: ;
      endcase
    end
  end

  assign sensor_mode = keyboard_mode_field[2:1] == 2'b10;
  assign strobe_mode = keyboard_mode_field[2:1] == 2'b11;
  assign kbd_mode = !keyboard_mode_field[2];
  assign decoded = keyboard_mode_field[0];

  // Prescaler to the internal timebase
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pre_cnt <= 5'h00;
      tick <= 1'b0;
    end else if (pre_cnt >= ((prescale_field < PRESCALE_MIN) ? PRESCALE_MIN : prescale_field)
                 - 5'h01) begin
      pre_cnt <= 5'h00;
      tick <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 5'h01;
      tick <= 1'b0;
    end
  end

  // Scan counter: one row/digit per DIGIT_TICKS timebase ticks
  assign digits = decoded ? 4'h4 : (disp_mode_field[0] ? 4'hf : 4'h7);
  assign row_end = tick && (phase == 6'(DIGIT_TICKS - 1));
  assign blank_phase = phase < 6'(BLANK_TICKS);

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      phase <= 6'h00;
      scan_row <= 4'h0;
    end else if (tick) begin
      phase <= row_end ? 6'h00 : phase + 6'h01;
      if (row_end) begin
        if (decoded) scan_row <= {2'h0, 2'(scan_row[1:0] + 2'h1)};
        else scan_row <= (scan_row >= digits) ? 4'h0 : scan_row + 4'h1;
      end
    end
  end

  // Key capture: debounce then confirm on the same row; other keys locked out
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      key_state <= KDS_IDLE;
      cand_row <= 3'h0;
      cand_col <= 3'h0;
      deb_cnt <= 11'h000;
      kbd_push <= 1'b0;
      key_code <= 8'h00;
    end else begin
      kbd_push <= 1'b0;
      if (!kbd_mode) begin
        key_state <= KDS_IDLE;
      end else begin
        unique case (key_state)
          KDS_IDLE: if (row_end && !scan_row[3] && rl != 8'hff) begin
            cand_row <= scan_row[2:0];
            cand_col <= low_col(rl);
            deb_cnt <= 11'h000;
            key_state <= KDS_DEBOUNCE;
          end
          KDS_DEBOUNCE: if (tick) begin
            if (deb_cnt == 11'(DEBOUNCE_TICKS - 1)) key_state <= KDS_CONFIRM;
            deb_cnt <= deb_cnt + 11'h001;
          end
          KDS_CONFIRM: if (row_end && scan_row == {1'b0, cand_row}) begin
            if (!rl[cand_col]) begin
              key_code <= {pin_q[PIN_CNTL], pin_q[PIN_SHIFT], cand_row, cand_col};
              kbd_push <= 1'b1;
              key_state <= KDS_HELD;
            end else begin
              key_state <= KDS_IDLE;
            end
          end
          KDS_HELD: if (row_end && scan_row == {1'b0, cand_row} && rl[cand_col]) begin
            key_state <= KDS_IDLE;
          end
        endcase
      end
    end
  end

  assign strobe_push = strobe_mode && pin_q[PIN_CNTL] && !cntl_d;
  assign push = kbd_push || strobe_push;
  assign sensor_we = sensor_mode && row_end && !scan_row[3];
  assign pop_req = rd_rise && !rd_a0 && !src_disp && !sensor_mode;

  // FIFO pointers, count and error flags; a set wins over a status-read clear
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
      count <= 4'h0;
      over_err <= 1'b0;
      under_err <= 1'b0;
    end else begin
      if (push && !count[3]) wr_ptr <= wr_ptr + 3'h1;
      if (pop_req && count != 4'h0) rd_ptr <= rd_ptr + 3'h1;
      count <= count + 4'((push && !count[3]) ? 1 : 0) - 4'((pop_req && count != 4'h0) ? 1 : 0);
      if (push && count[3]) over_err <= 1'b1;
      else if (rd_fall && pin_q[PIN_A0]) over_err <= 1'b0;
      if (pop_req && count == 4'h0) under_err <= 1'b1;
      else if (rd_fall && pin_q[PIN_A0]) under_err <= 1'b0;
    end
  end

  // Sensor interrupt on change, cleared by a sensor data read
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      sensor_irq <= 1'b0;
    end else if (sensor_we && rl != fifo_q_b) begin
      sensor_irq <= 1'b1;
    end else if (rd_rise && !rd_a0 && !src_disp) begin
      sensor_irq <= 1'b0;
    end
  end

  kds_ram #(.WIDTH(8), .DEPTH(8)) u_fifo_ram (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_we(sensor_we || (push && !count[3])),
    .i_waddr(sensor_mode ? scan_row[2:0] : wr_ptr),
    .i_wdata(sensor_mode ? rl : (kbd_push ? key_code : rl)),
    .i_raddr_a(sensor_mode ? sens_ptr : rd_ptr),
    .o_rdata_a(fifo_q_a),
    .i_raddr_b(scan_row[2:0]),
    .o_rdata_b(fifo_q_b)
  );

  // Read source, sensor row and display address
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      src_disp <= 1'b0;
      auto_increment_flag <= 1'b0;
      sens_ptr <= 3'h0;
      disp_auto_inc <= 1'b0;
      disp_addr <= 4'h0;
    end else if (wr_rise && wr_a0) begin
      if (wr_data[7:5] == CMD_READ_FIFO) begin
        src_disp <= 1'b0;
        auto_increment_flag <= wr_data[4];
        sens_ptr <= wr_data[2:0];
      end else if (wr_data[7:5] == CMD_READ_DISP || wr_data[7:5] == CMD_WRITE_DISP) begin
        if (wr_data[7:5] == CMD_READ_DISP) src_disp <= 1'b1;
        disp_auto_inc <= wr_data[4];
        disp_addr <= wr_data[3:0];
      end
    end else if ((wr_rise && !wr_a0) || (rd_rise && !rd_a0 && src_disp)) begin
      if (disp_auto_inc) disp_addr <= disp_addr + 4'h1;
    end else if (rd_rise && !rd_a0 && sensor_mode && auto_increment_flag) begin
      sens_ptr <= sens_ptr + 3'h1;
    end
  end

  assign disp_we = wr_rise && !wr_a0;

  kds_ram #(.WIDTH(8), .DEPTH(16)) u_disp_ram (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_we(disp_we),
    .i_waddr(disp_addr),
    .i_wdata({iw_a ? disp_q_a[7:4] : wr_data[7:4], iw_b ? disp_q_a[3:0] : wr_data[3:0]}),
    .i_raddr_a(disp_addr),
    .o_rdata_a(disp_q_a),
    .i_raddr_b(decoded ? {2'h0, scan_row[1:0]} : scan_row),
    .o_rdata_b(disp_q_b)
  );

  // Host read data and bus enable
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_DB <= 8'h00;
      rd_hold <= 1'b0;
    end else begin
      if (rd_fall) begin
        if (pin_q[PIN_A0]) begin
          O_DB <= {2'h0, over_err, under_err, count[3], count[2:0]};
        end else begin
          O_DB <= src_disp ? disp_q_a : fifo_q_a;
        end
      end
      if (rd_fall && !pin_q[PIN_A0] && !src_disp) rd_hold <= 1'b1;
      else if (!rd_act) rd_hold <= 1'b0;
    end
  end

  assign O_DB_OE = rd_act && rd_act_d;

  // Interrupt, scan lines and display refresh outputs
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_IRQ <= 1'b0;
      O_SCAN_LINES <= 4'h0;
      row_start <= 1'b0;
      O_OUT_A <= 4'h0;
      O_OUT_B <= 4'h0;
      O_BLANK_DISPLAY_OUT_N <= 1'b0;
    end else begin
      O_IRQ <= sensor_mode ? sensor_irq : (count != 4'h0 && !rd_hold);
      row_start <= row_end;
      // Scan lines move only at a row start, so every change falls in the blank phase
      if (row_start) O_SCAN_LINES <= decoded ? ~(4'h1 << scan_row[1:0]) : scan_row;
      O_OUT_A <= (blank_phase || bl_a) ? 4'h0 : disp_q_b[7:4];
      O_OUT_B <= (blank_phase || bl_b) ? 4'h0 : disp_q_b[3:0];
      O_BLANK_DISPLAY_OUT_N <= !(blank_phase || (bl_a && bl_b));
    end
  end
endmodule : kds_top

// ---- test/kds_host.sv ----
/*
 Host bus model: command, status and data cycles on the scanner's pins.
 Assumes the device filters every pin through synchronisers on i_clk.
*/
`timescale 1ns/100ps
module kds_host (
  input wire logic i_clk,
  input wire logic [7:0] i_db,
  input wire logic i_oe,
  output logic o_cs_n,
  output logic o_a0,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic [7:0] o_db
);
  initial begin
    o_cs_n = 1'b1;
    o_a0 = 1'b0;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_db = 8'h00;
  end

  // Strobe held 10 clocks, then 8 idle clocks before the next access
  task automatic wr(input logic a0, input logic [7:0] data);
    @(posedge i_clk);
    #1;
    o_cs_n = 1'b0;
    o_a0 = a0;
    o_wr_n = 1'b0;
    o_db = data;
    repeat (10) @(posedge i_clk);
    #1;
    o_wr_n = 1'b1;
    o_cs_n = 1'b1;
    o_db = ~data;
    repeat (8) @(posedge i_clk);
  endtask : wr

  task automatic rd(input logic a0, output logic [7:0] data, output logic oe);
    @(posedge i_clk);
    #1;
    o_cs_n = 1'b0;
    o_a0 = a0;
    o_rd_n = 1'b0;
    repeat (10) @(posedge i_clk);
    data = i_db;
    oe = i_oe;
    #1;
    o_rd_n = 1'b1;
    o_cs_n = 1'b1;
    repeat (8) @(posedge i_clk);
  endtask : rd
endmodule : kds_host

// ---- test/kds_top_properties.sv ----
/*
 Port checker for kds_top.
 Assumes one clock domain with an asynchronous active-high reset.
*/
`timescale 1ns/100ps
module kds_top_chk (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_CS_N,
  input wire logic I_RD_N,
  input wire logic [7:0] O_DB,
  input wire logic O_DB_OE,
  input wire logic O_IRQ,
  input wire logic [3:0] O_SCAN_LINES,
  input wire logic [3:0] O_OUT_A,
  input wire logic [3:0] O_OUT_B,
  input wire logic O_BLANK_DISPLAY_OUT_N
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  property p_oe_cs;
    I_CS_N [*8] |-> !O_DB_OE;
  endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("bus driven while deselected");
  property p_oe_rd;
    I_RD_N [*8] |-> !O_DB_OE;
  endproperty
  a_oe_rd: assert property (p_oe_rd) else $error("bus driven without read");
  property p_oe_cause;
    $rose(O_DB_OE) |-> $past(!I_CS_N && !I_RD_N, 3);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("drive began without read");
  property p_db_hold;
    O_DB_OE && $past(O_DB_OE) |-> $stable(O_DB);
  endproperty
  a_db_hold: assert property (p_db_hold) else $error("read data moved while driven");
  property p_blank_zero;
    !O_BLANK_DISPLAY_OUT_N |-> (O_OUT_A == 4'h0) && (O_OUT_B == 4'h0);
  endproperty
  a_blank_zero: assert property (p_blank_zero) else $error("nibbles shown while blank");
  property p_scan_blank;
    $changed(O_SCAN_LINES) |-> ##[0:1] !O_BLANK_DISPLAY_OUT_N;
  endproperty
  a_scan_blank: assert property (p_scan_blank) else $error("digit switch not blanked");
  property p_blank_len;
    $fell(O_BLANK_DISPLAY_OUT_N) |=> !O_BLANK_DISPLAY_OUT_N [*8];
  endproperty
  a_blank_len: assert property (p_blank_len) else $error("blank phase too short");
  property p_scan_hold;
    $changed(O_SCAN_LINES) |=> $stable(O_SCAN_LINES) [*8];
  endproperty
  a_scan_hold: assert property (p_scan_hold) else $error("scan row too short");
  property p_reset_out;
    $fell(I_RST) |-> !O_IRQ && !O_DB_OE && !O_BLANK_DISPLAY_OUT_N;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs wrong after reset");
endmodule : kds_top_chk

bind kds_top kds_top_chk chk_u (.I_CLK(I_CLK), .I_RST(I_RST), .I_CS_N(I_CS_N),
  .I_RD_N(I_RD_N), .O_DB(O_DB), .O_DB_OE(O_DB_OE), .O_IRQ(O_IRQ),
  .O_SCAN_LINES(O_SCAN_LINES), .O_OUT_A(O_OUT_A), .O_OUT_B(O_OUT_B),
  .O_BLANK_DISPLAY_OUT_N(O_BLANK_DISPLAY_OUT_N));

// ---- test/testbench.sv ----
/*
 Self-checking bench for kds_top.
 Assumes the host model on the bus and return lines pulled high when idle.
*/
`timescale 1ns/100ps
module testbench;
  import kds_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, a0, rd_n, wr_n, oe, irq, shift, stb, blank_n, key, o;
  logic [7:0] db_in, db_out, rl_stb, rl, d;
  logic [3:0] scan, out_a, out_b;
  int err_count = 0;
  int num_checks = 0;

  always #20 clk = ~clk;
  // Key at row 3, column 2 pulls its return line low while its row is scanned
  assign rl = (key && scan == 4'h3) ? 8'hfb : rl_stb;

  kds_host host_u (.i_clk(clk), .i_db(db_out), .i_oe(oe), .o_cs_n(cs_n), .o_a0(a0),
    .o_rd_n(rd_n), .o_wr_n(wr_n), .o_db(db_in));
  kds_top dut_u (.I_CLK(clk), .I_RST(rst), .I_CS_N(cs_n), .I_A0(a0), .I_RD_N(rd_n),
    .I_WR_N(wr_n), .I_DB(db_in), .O_DB(db_out), .O_DB_OE(oe), .O_IRQ(irq),
    .O_SCAN_LINES(scan), .I_RETURN_LINES(rl), .I_SHIFT(shift),
    .I_CONTROL_STROBE_INPUT(stb), .O_OUT_A(out_a), .O_OUT_B(out_b),
    .O_BLANK_DISPLAY_OUT_N(blank_n));

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic t_reset();
    repeat (2) @(posedge clk);
    chk("oe_rst", {7'h0, oe}, 8'h00);
    chk("irq_rst", {7'h0, irq}, 8'h00);
    chk("blank_rst", {7'h0, blank_n}, 8'h00);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    host_u.rd(1'b1, d, o);
    chk("status_rst", d, 8'h00);
    chk("oe_read", {7'h0, o}, 8'h01);
  endtask : t_reset

  task automatic t_strobe();
    host_u.wr(1'b1, 8'h22);
    host_u.wr(1'b1, 8'h06);
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      #1;
      rl_stb = 8'h10 + 8'(i);
      stb = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      stb = 1'b1;
      repeat (6) @(posedge clk);
    end
    #1;
    rl_stb = 8'hff;
    chk("irq_full", {7'h0, irq}, 8'h01);
    host_u.rd(1'b1, d, o);
    chk("status_over", d, 8'h28);
    host_u.rd(1'b1, d, o);
    chk("status_full", d, 8'h08);
    host_u.wr(1'b1, 8'h57);
    for (int i = 0; i < 8; i++) begin
      host_u.rd(1'b0, d, o);
      chk("fifo_data", d, 8'h10 + 8'(i));
      chk("irq_after_read", {7'h0, irq}, {7'h0, i < 7});
    end
    host_u.rd(1'b0, d, o);
    host_u.rd(1'b1, d, o);
    chk("status_under", d, 8'h10);
  endtask : t_strobe

  task automatic t_key();
    host_u.wr(1'b1, 8'h00);
    #1;
    shift = 1'b1;
    key = 1'b1;
    for (int k = 0; k < 20000 && irq !== 1'b1; k++) @(posedge clk);
    chk("key_irq", {7'h0, irq}, 8'h01);
    if (irq !== 1'b1) end_sim();
    #1;
    key = 1'b0;
    host_u.wr(1'b1, 8'h40);
    host_u.rd(1'b0, d, o);
    chk("key_code", d, 8'hda);
  endtask : t_key

  task automatic t_disp();
    logic [3:0] seen;
    logic hi;
    seen = 4'h0;
    hi = 1'b0;
    host_u.wr(1'b1, 8'h01);
    host_u.wr(1'b1, 8'h90);
    host_u.wr(1'b0, 8'ha5);
    host_u.wr(1'b0, 8'h3c);
    host_u.wr(1'b1, 8'h70);
    host_u.rd(1'b0, d, o);
    chk("disp_rd0", d, 8'ha5);
    host_u.rd(1'b0, d, o);
    chk("disp_rd1", d, 8'h3c);
    // Decoded scan lines only appear at the next row start
    repeat (130) @(posedge clk);
    repeat (600) begin
      @(posedge clk);
      #1;
      seen = seen | ~scan;
      chk("scan_cold", {7'h0, scan inside {4'he, 4'hd, 4'hb, 4'h7}}, 8'h01);
      if (scan == 4'he && blank_n) chk("nibbles", {out_a, out_b}, 8'ha5);
    end
    chk("scan_rows", {4'h0, seen}, 8'h0f);
    host_u.wr(1'b1, 8'ha3);
    repeat (300) begin
      @(posedge clk);
      #1;
      hi = hi | blank_n;
    end
    chk("blank_cmd", {7'h0, hi}, 8'h00);
  endtask : t_disp

  initial begin
    shift = 1'b0;
    stb = 1'b1;
    key = 1'b0;
    rl_stb = 8'hff;
    t_reset();
    t_strobe();
    t_key();
    t_disp();
    end_sim();
  end
endmodule : testbench
